// ### core/ptb_pkg.sv
// Purpose: Constants for the PWM master time base configuration block.
// Assumes: 16-bit registers on a plain strobe port, one register per index.
// Notes: Offsets are register indices on the plain port.
package ptb_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_CLKDIV = 3'h1;
    localparam logic [2:0] ADDR_PERIOD = 3'h2;
    localparam logic [2:0] ADDR_CMP = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STAT = 3'h4;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
    localparam logic [2:0] ADDR_COUNT = 3'h6;
    localparam int CTRL_ON_BIT = 15;
    localparam int PS_LSB = 0;
    localparam int PS_W = 4;
    localparam int DIV_W = 3;
    localparam logic [2:0] DIV_RESERVED = 3'h7;
    localparam logic [15:0] PERIOD_RST = 16'hfff8;
    localparam logic [15:0] CMP_MASK = 16'hfff8;
    localparam logic [15:0] CTRL_MASK = 16'h800f;
    localparam int IRQ_W = 2;
    localparam int IRQ_MATCH = 0;
    localparam int IRQ_TRIG = 1;
endpackage : ptb_pkg

// ### core/ptb_postscaler.sv
// Purpose: Passes every Nth compare match on as a special event trigger.
// Assumes: N is the postscale code plus one.
// Notes: Counter restarts while the module is off.
`timescale 1ns/1ps
`default_nettype none
module ptb_postscaler (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic run_in,
    input wire logic match_in,
    input wire logic [3:0] code_in,
    output logic trig_out
);
    logic [3:0] cnt_r;
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_r <= 4'h0;
            trig_out <= 1'b0;
        end else if (!run_in) begin
            cnt_r <= 4'h0;
            trig_out <= 1'b0;
        end else if (match_in) begin
            if (cnt_r >= code_in) begin
                cnt_r <= 4'h0;
                trig_out <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 4'h1;
                trig_out <= 1'b0;
            end
        end else begin
            trig_out <= 1'b0;
        end
    end
    a_post_every: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (run_in && match_in && code_in == 4'h0) |=> trig_out)
        else $error("Code zero did not pass a match.");
    a_post_nomatch: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !match_in |=> !trig_out)
        else $error("Trigger without a match.");
endmodule : ptb_postscaler
`default_nettype wire

// ### core/ptb_prescaler.sv
// Purpose: Divides the PWM input clock into a one-cycle enable pulse.
// Assumes: Code changes only while the module is off.
// Notes: The reserved code holds the enable low.
`timescale 1ns/1ps
`default_nettype none
module ptb_prescaler (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic run_in,
    input wire logic [2:0] code_in,
    output logic tick_out
);
    logic [5:0] cnt_r;
    logic [5:0] limit;
    assign limit = 6'(7'h7f >> (7 - {4'h0, code_in}));
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_r <= 6'h00;
            tick_out <= 1'b0;
        end else if (!run_in || code_in == ptb_pkg::DIV_RESERVED) begin
            cnt_r <= 6'h00;
            tick_out <= 1'b0;
        end else if (cnt_r >= limit) begin
            cnt_r <= 6'h00;
            tick_out <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 6'h01;
            tick_out <= 1'b0;
        end
    end
    a_div_spacing: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (run_in && code_in == 3'h1 && $stable(code_in) && tick_out) |=> !tick_out)
        else $error("Divide-by-2 tick not spaced.");
endmodule : ptb_prescaler
`default_nettype wire

// ### core/ptb_time_base.sv
// Purpose: PWM master time base configuration, counter and special event trigger.
// Assumes: Registers on a plain strobe port; read data valid one cycle after the strobe.
// Notes: Only the enable and postscale bits of the control register are held here.
// Overview of operation
// - Trigger passes every Nth compare match, N equals postscale code plus one.
// - Prescaler divides PWM clock by 1 to 64; code 111 reserved.
// - A 16-bit read/write period value sets the counter period.
// - Compare count lives in bits 15..3, read/write, resets to zero.
// - Compare bits 2..0 read back as zero.
// - Clock divider bits 15..3 read zero; only low three bits writable.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ptb_time_base #(
    parameter int DATA_W = ptb_pkg::DATA_W
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [2:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    output logic event_trig_out,
    output logic irq_out
);
    logic pwm_module_on_r;
    logic [3:0] event_trigger_postscale_r;
    logic [2:0] pwm_clock_prescale_r;
    logic [15:0] master_period_value_r;
    logic [15:0] event_compare_value_r;
    logic [15:0] master_time_base_counter_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic match_r;
    logic tick;
    logic trig;
    logic [1:0] events;
    logic stat_rd;
    logic [6:0] tick_gap_r;
    logic tick_seen_r;

    default clocking cb_main @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    function automatic logic hit(input logic [2:0] a);
        return wr_in && addr_in == a;
    endfunction : hit

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pwm_module_on_r <= 1'b0;
            event_trigger_postscale_r <= 4'h0;
        end else if (hit(ptb_pkg::ADDR_CTRL)) begin
            pwm_module_on_r <= wdata_in[ptb_pkg::CTRL_ON_BIT];
            event_trigger_postscale_r <= wdata_in[ptb_pkg::PS_LSB +: ptb_pkg::PS_W];
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pwm_clock_prescale_r <= 3'h0;
        end else if (hit(ptb_pkg::ADDR_CLKDIV)) begin
            pwm_clock_prescale_r <= wdata_in[ptb_pkg::DIV_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            master_period_value_r <= ptb_pkg::PERIOD_RST;
        end else if (hit(ptb_pkg::ADDR_PERIOD)) begin
            master_period_value_r <= wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            event_compare_value_r <= 16'h0000;
        end else if (hit(ptb_pkg::ADDR_CMP)) begin
            event_compare_value_r <= wdata_in & ptb_pkg::CMP_MASK;
        end
    end

    ptb_prescaler u_pre (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .run_in(pwm_module_on_r),
        .code_in(pwm_clock_prescale_r),
        .tick_out(tick)
    );

    // The counter wraps at the period value; an out-of-range period is
    // tolerated but gives the software-visible behaviour of a short or long cycle.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            master_time_base_counter_r <= 16'h0000;
        end else if (!pwm_module_on_r) begin
            master_time_base_counter_r <= 16'h0000;
        end else if (tick) begin
            if (master_time_base_counter_r >= master_period_value_r) begin
                master_time_base_counter_r <= 16'h0000;
            end else begin
                master_time_base_counter_r <= master_time_base_counter_r + 16'h0001;
            end
        end
    end

    // Match fires once per counter step, not for every fast clock spent on the value.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            match_r <= 1'b0;
        end else begin
            match_r <= pwm_module_on_r && tick &&
                master_time_base_counter_r == event_compare_value_r;
        end
    end

    ptb_postscaler u_post (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .run_in(pwm_module_on_r),
        .match_in(match_r),
        .code_in(event_trigger_postscale_r),
        .trig_out(trig)
    );

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            event_trig_out <= 1'b0;
        end else begin
            event_trig_out <= trig;
        end
    end

    assign events = {trig, match_r};
    assign stat_rd = rd_in && addr_in == ptb_pkg::ADDR_IRQ_STAT;

    // A new event in the same cycle as the clearing read stays pending.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_stat_r <= 2'h0;
        end else begin
            irq_stat_r <= (stat_rd ? 2'h0 : irq_stat_r) | events;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_mask_r <= 2'h0;
        end else if (hit(ptb_pkg::ADDR_IRQ_MASK)) begin
            irq_mask_r <= wdata_in[ptb_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(((stat_rd ? 2'h0 : irq_stat_r) | events) & irq_mask_r);
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            case (addr_in)
                ptb_pkg::ADDR_CTRL: rdata_out <= {pwm_module_on_r, 11'h000,
                    event_trigger_postscale_r};
                ptb_pkg::ADDR_CLKDIV: rdata_out <= {13'h0000, pwm_clock_prescale_r};
                ptb_pkg::ADDR_PERIOD: rdata_out <= master_period_value_r;
                ptb_pkg::ADDR_CMP: rdata_out <= event_compare_value_r;
                ptb_pkg::ADDR_IRQ_STAT: rdata_out <= {14'h0000, irq_stat_r};
                ptb_pkg::ADDR_IRQ_MASK: rdata_out <= {14'h0000, irq_mask_r};
                ptb_pkg::ADDR_COUNT: rdata_out <= master_time_base_counter_r;
                default: rdata_out <= '0;
            endcase
        end else begin
            rdata_out <= '0;
        end
    end

    // Cycles since the last prescaler tick, read only by the checks below. It restarts
    // while the module is off, the only time the divider code may be changed.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tick_gap_r <= 7'h00;
            tick_seen_r <= 1'b0;
        end else if (!pwm_module_on_r) begin
            tick_gap_r <= 7'h00;
            tick_seen_r <= 1'b0;
        end else if (tick) begin
            tick_gap_r <= 7'h01;
            tick_seen_r <= 1'b1;
        end else if (tick_gap_r != 7'h7f) begin
            tick_gap_r <= tick_gap_r + 7'h01;
        end
    end

    // Trigger path stages: compare hit on a tick, match, postscaler pulse, output.
    sequence s_cmp_hit;
        pwm_module_on_r && tick && master_time_base_counter_r == event_compare_value_r;
    endsequence : s_cmp_hit
    sequence s_pass_all;
        match_r && pwm_module_on_r && event_trigger_postscale_r == 4'h0;
    endsequence : s_pass_all

    a_cmp_low_zero: assert property (
        event_compare_value_r[2:0] == 3'h0)
        else $error("Compare low bits not zero.");
    a_period_write: assert property (
        (wr_in && addr_in == ptb_pkg::ADDR_PERIOD) |=> master_period_value_r == $past(wdata_in))
        else $error("Period write lost.");
    a_cmp_write: assert property (
        (wr_in && addr_in == ptb_pkg::ADDR_CMP)
        |=> event_compare_value_r[15:3] == $past(wdata_in[15:3]))
        else $error("Compare write lost.");
    a_div_readback: assert property (
        (rd_in && addr_in == ptb_pkg::ADDR_CLKDIV) |=> rdata_out[15:3] == 13'h0000)
        else $error("Divider upper bits not zero.");
    a_match_cause: assert property (
        s_cmp_hit |=> match_r)
        else $error("Compare match missed.");
    a_trig_follow: assert property (
        event_trig_out |-> $past(trig))
        else $error("Trigger output without postscaler pulse.");
    a_count_bound: assert property (
        (tick && master_time_base_counter_r >= master_period_value_r)
        |=> master_time_base_counter_r == 16'h0000)
        else $error("Counter did not wrap at period.");
    a_div_reset: assert property (
        $fell(sys_rst_in) |-> pwm_clock_prescale_r == 3'h0)
        else $error("Prescaler not zero after reset.");
    a_period_reset: assert property (
        $fell(sys_rst_in) |-> master_period_value_r == ptb_pkg::PERIOD_RST)
        else $error("Period not at its reset value after reset.");
    a_cmp_reset: assert property (
        $fell(sys_rst_in) |-> event_compare_value_r == 16'h0000)
        else $error("Compare value not zero after reset.");
    a_div_write: assert property (
        (wr_in && addr_in == ptb_pkg::ADDR_CLKDIV)
        |=> pwm_clock_prescale_r == $past(wdata_in[2:0]))
        else $error("Divider write lost.");
    a_period_hold: assert property (
        !(wr_in && addr_in == ptb_pkg::ADDR_PERIOD)
        |=> $stable(master_period_value_r))
        else $error("Period changed without a write.");
    a_cmp_hold: assert property (
        !(wr_in && addr_in == ptb_pkg::ADDR_CMP)
        |=> $stable(event_compare_value_r))
        else $error("Compare value changed without a write.");
    a_cmp_readback: assert property (
        (rd_in && addr_in == ptb_pkg::ADDR_CMP) |=> rdata_out[2:0] == 3'h0)
        else $error("Compare low bits read back set.");
    a_period_readback: assert property (
        (rd_in && addr_in == ptb_pkg::ADDR_PERIOD) |=> rdata_out == $past(master_period_value_r))
        else $error("Period read back wrong.");
    a_ctrl_readback: assert property (
        (rd_in && addr_in == ptb_pkg::ADDR_CTRL) |=> rdata_out ==
        {$past(pwm_module_on_r), 11'h000, $past(event_trigger_postscale_r)})
        else $error("Control read back wrong.");
    a_read_idle: assert property (
        !rd_in |=> rdata_out == 16'h0000)
        else $error("Read data not zero outside a read.");
    a_reserved_stop: assert property (
        (pwm_clock_prescale_r == ptb_pkg::DIV_RESERVED) |=> !tick)
        else $error("Reserved divider code still ticks.");
    a_tick_undiv: assert property (
        (pwm_module_on_r && pwm_clock_prescale_r == 3'h0) |=> tick)
        else $error("Undivided clock did not tick.");
    a_tick_period: assert property (
        (pwm_module_on_r && tick && tick_seen_r)
        |-> tick_gap_r == 7'(7'h01 << pwm_clock_prescale_r))
        else $error("Prescaler tick spacing wrong.");
    a_count_off: assert property (
        !pwm_module_on_r |=> master_time_base_counter_r == 16'h0000)
        else $error("Counter not cleared while off.");
    a_count_hold: assert property (
        (pwm_module_on_r && !tick) |=> $stable(master_time_base_counter_r))
        else $error("Counter moved without a tick.");
    a_count_step: assert property (
        (pwm_module_on_r && tick && master_time_base_counter_r < master_period_value_r)
        |=> master_time_base_counter_r == $past(master_time_base_counter_r) + 16'h0001)
        else $error("Counter did not step by one.");
    a_trig_chain: assert property (
        s_cmp_hit ##1 s_pass_all |=> ##1 event_trig_out)
        else $error("Compare hit did not reach the trigger output.");
    a_trig_off: assert property (
        !pwm_module_on_r |=> !trig)
        else $error("Trigger while the module is off.");
    a_trig_cause: assert property (
        trig |-> $past(match_r))
        else $error("Postscaler pulse without a match.");
    a_stat_set: assert property (
        (|events) |=> (irq_stat_r & $past(events)) == $past(events))
        else $error("Event not recorded in status.");
    a_stat_clear: assert property (
        (stat_rd && events == 2'h0) |=> irq_stat_r == 2'h0)
        else $error("Status read did not clear.");
    a_irq_level: assert property (
        irq_out == |(irq_stat_r & $past(irq_mask_r)))
        else $error("Interrupt line does not follow masked status.");
endmodule : ptb_time_base
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the PWM master time base configuration block.
// Assumes: Plain strobe register port, read data valid only in the cycle after the strobe.
// Notes: Trigger spacing is measured between two triggers, so the start phase is irrelevant.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [2:0] addr_in = 3'h0;
    logic [15:0] wdata_in = 16'h0000;
    wire logic [15:0] rdata_out;
    wire logic event_trig_out;
    wire logic irq_out;
    int num_errors = 0;
    int samples_checked = 0;
    int ps_list [3] = '{1, 7, 15};
    int seen;
    always #2.5 ref_clk_in = ~ref_clk_in;
    ptb_time_base i_dut (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .event_trig_out(event_trig_out),
        .irq_out(irq_out)
    );
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
        @(posedge ref_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask : rchk
    task automatic wait_trig(output int n);
        n = 0;
        do begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end while (event_trig_out !== 1'b1 && n < 4000);
        if (n >= 4000) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, 1'b0, 1'b1);
            tally_and_finish();
        end
    endtask : wait_trig
    // Period 0x0010 gives 17 ticks per count cycle, each tick 2**d clocks apart.
    task automatic interval(input logic [2:0] d, input logic [3:0] p);
        int n;
        wr(ptb_pkg::ADDR_CTRL, 16'h0000);
        wr(ptb_pkg::ADDR_CLKDIV, {13'h0000, d});
        wr(ptb_pkg::ADDR_CTRL, {12'h800, p});
        wait_trig(n);
        wait_trig(n);
        chk(16'(n), 16'(17 * (1 << d) * (p + 1)));
    endtask : interval
    initial begin
        repeat (5) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rchk(ptb_pkg::ADDR_PERIOD, ptb_pkg::PERIOD_RST);
        rchk(ptb_pkg::ADDR_CMP, 16'h0000);
        rchk(ptb_pkg::ADDR_CLKDIV, 16'h0000);
        wr(ptb_pkg::ADDR_PERIOD, 16'h1234);
        rchk(ptb_pkg::ADDR_PERIOD, 16'h1234);
        wr(ptb_pkg::ADDR_CMP, 16'hffff);
        rchk(ptb_pkg::ADDR_CMP, 16'hfff8);
        wr(ptb_pkg::ADDR_CLKDIV, 16'hffff);
        rchk(ptb_pkg::ADDR_CLKDIV, 16'h0007);
        wr(3'h7, 16'hffff);
        rchk(3'h7, 16'h0000);
        rchk(ptb_pkg::ADDR_COUNT, 16'h0000);
        // No external sync reaches this block, so any legal period serves.
        wr(ptb_pkg::ADDR_PERIOD, 16'h0010);
        wr(ptb_pkg::ADDR_CMP, 16'h0008);
        wr(ptb_pkg::ADDR_IRQ_MASK, 16'h0000);
        for (int d = 0; d < 7; d++) begin
            interval(3'(d), 4'h0);
        end
        interval(3'h0, 4'h0);
        foreach (ps_list[i]) begin
            interval(3'h0, 4'(ps_list[i]));
        end
        // Both events are pending but masked, so the line must stay low.
        wr(ptb_pkg::ADDR_CTRL, 16'h0000);
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk({15'h0000, irq_out}, 16'h0000);
        wr(ptb_pkg::ADDR_IRQ_MASK, 16'h0003);
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk({15'h0000, irq_out}, 16'h0001);
        rchk(ptb_pkg::ADDR_IRQ_STAT, 16'h0003);
        rchk(ptb_pkg::ADDR_IRQ_STAT, 16'h0000);
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk({15'h0000, irq_out}, 16'h0000);
        rchk(ptb_pkg::ADDR_IRQ_MASK, 16'h0003);
        wr(ptb_pkg::ADDR_CTRL, 16'h7ff5);
        rchk(ptb_pkg::ADDR_CTRL, 16'h0005);
        // The reserved divider code stops the count, so no trigger may appear.
        wr(ptb_pkg::ADDR_CLKDIV, 16'h0007);
        wr(ptb_pkg::ADDR_CTRL, 16'h8000);
        seen = 0;
        repeat (1500) begin
            @(posedge ref_clk_in);
            #1;
            if (event_trig_out === 1'b1) begin
                seen++;
            end
        end
        chk(16'(seen), 16'h0000);
        rchk(ptb_pkg::ADDR_COUNT, 16'h0000);
        rchk(ptb_pkg::ADDR_CTRL, 16'h8000);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
